// ==== aows_pkg.sv ====
// shared constants for the analog output waveform sequencer
package aows_pkg;
	localparam int BUS_W = 32;
	localparam int ADDR_W = 6;
	localparam int SIB_LINES = 7;
	localparam int SEL_W = 5;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_CFG = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_SRC = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_REF = 6'h0C;
	localparam logic [ADDR_W-1:0] OFF_RGL = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_CNT = 6'h14;
	localparam logic [ADDR_W-1:0] OFF_DIV = 6'h18;
	localparam logic [ADDR_W-1:0] OFF_DLY = 6'h1C;
	localparam logic [ADDR_W-1:0] OFF_DATA = 6'h20;
	localparam logic [ADDR_W-1:0] OFF_STAT = 6'h24;

	// control command bits (write pulses)
	localparam int CTRL_GO = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_CLR = 2;

	// configuration bits
	localparam int CFG_W = 10;
	localparam int CFG_HW = 0;
	localparam int CFG_EXTCLK = 1;
	localparam int CFG_CONT = 2;
	localparam int CFG_REGEN = 3;
	localparam int CFG_TRIG_EN = 5;
	localparam int CFG_TRIG_FALL = 6;
	localparam int CFG_PAUSE_EN = 7;
	localparam int CFG_PAUSE_HI = 8;
	localparam int CFG_TRIG_OUT = 9;
	localparam logic [CFG_W-1:0] CFG_RST = 10'h000;

	localparam logic [1:0] REGEN_STD = 2'h0;
	localparam logic [1:0] REGEN_FIFO = 2'h1;
	localparam logic [1:0] REGEN_NONE = 2'h2;

	// source select fields
	localparam int SRC_W = 21;
	localparam int SRC_START = 0;
	localparam int SRC_PAUSE = 8;
	localparam int SRC_CLK = 16;
	localparam logic [SRC_W-1:0] SRC_RST = 21'h000000;

	// status bits
	localparam int STAT_RUN = 0;
	localparam int STAT_UF = 1;
	localparam int STAT_FULL = 2;
	localparam int STAT_EMPTY = 3;
	localparam int STAT_ARMED = 4;
	localparam int STAT_LVL = 8;

	localparam logic [31:0] CNT_RST = 32'h00000000;
	localparam logic [15:0] DIV_RST = 16'h0002;
	localparam logic [15:0] DLY_RST = 16'h0002;

	typedef enum logic [1:0] {
		AOWS_IDLE,
		AOWS_ARMED,
		AOWS_DELAY,
		AOWS_RUN
	} aows_state_t;
endpackage : aows_pkg

// ==== aows_sequencer.sv ====
// waveform sequencer: avalon registers, output fifo, start/pause, sample clock
`timescale 1ns/1ps
module aows_sequencer import aows_pkg::*; #(
	parameter int N_CH = 2,
	parameter int DAC_W = 16,
	parameter int FIFO_DEPTH = 16,
	parameter int N_PFI = 9,
	parameter int N_INT = 4
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [BUS_W-1:0] avs_writedata,
	output logic [BUS_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sample_clock_timebase,
	input wire logic [N_PFI-1:0] pfi_in,
	input wire logic [SIB_LINES-1:0] sib_line,
	input wire logic [N_INT-1:0] int_sig,
	input wire logic start_trigger_pin_i,
	output logic start_trigger_pin_o,
	output logic start_trigger_pin_oe,
	output logic output_sample_clock,
	output logic [N_CH*DAC_W-1:0] dac_data,
	output logic dac_update,
	output logic [N_CH-1:0] ref_ext_sel,
	output logic [N_CH-1:0] reglitch_en
);
	localparam int SMP_W = N_CH * DAC_W;
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int N_SRC = 1 + N_PFI + SIB_LINES + N_INT;
	localparam logic [AW:0] FULL_LVL = (AW+1)'(FIFO_DEPTH);

	typedef struct packed {
		logic wait_q;
		logic [BUS_W-1:0] rdata_q;
		logic [CFG_W-1:0] cfg_q;
		logic [SRC_W-1:0] src_q;
		logic [N_CH-1:0] ref_q;
		logic [N_CH-1:0] rgl_q;
		logic [31:0] cnt_q;
		logic [15:0] div_q;
		logic [15:0] dly_q;
		aows_state_t st_q;
		logic [FIFO_DEPTH-1:0][SMP_W-1:0] mem_q;
		logic [AW-1:0] wr_q;
		logic [AW-1:0] rd_q;
		logic [AW-1:0] base_q;
		logic [AW:0] lvl_q;
		logic uf_q;
		logic [15:0] tb_cnt_q;
		logic [31:0] smp_q;
		logic tb_prev_q;
		logic [N_SRC-1:0] src_prev_q;
		logic strt_q;
		logic sclk_q;
		logic [SMP_W-1:0] dac_q;
		logic upd_q;
	} aows_regs_t;

	aows_regs_t q;
	aows_regs_t n;
	logic [N_SRC-1:0] src_vec;
	logic [BUS_W-1:0] rd_val;
	logic commit, go, stop, clr, push, pop, fire, start;
	logic hw, ext, cont, locked, paused, tb_edge, trig_edge, clk_edge;
	logic [1:0] regen;

	// index 0 is the start pin itself, so the reset selection uses it
	assign src_vec = {int_sig, sib_line, pfi_in, start_trigger_pin_i};

	function automatic logic pick(input logic [N_SRC-1:0] v,
		input logic [SEL_W-1:0] sel);
		pick = (int'(sel) < N_SRC) ? v[sel] : 1'b0;
	endfunction : pick

	assign hw = q.cfg_q[CFG_HW];
	assign ext = q.cfg_q[CFG_EXTCLK];
	assign cont = q.cfg_q[CFG_CONT];
	assign regen = q.cfg_q[CFG_REGEN +: 2];
	assign locked = (regen == REGEN_FIFO) && (q.st_q != AOWS_IDLE);
	assign commit = avs_write & ~q.wait_q;
	assign tb_edge = sample_clock_timebase & ~q.tb_prev_q;
	assign paused = q.cfg_q[CFG_PAUSE_EN] && (pick(src_vec,
		q.src_q[SRC_PAUSE +: SEL_W]) == q.cfg_q[CFG_PAUSE_HI]);
	assign clk_edge = pick(src_vec, q.src_q[SRC_CLK +: SEL_W])
		& ~pick(q.src_prev_q, q.src_q[SRC_CLK +: SEL_W]);
	assign trig_edge = q.cfg_q[CFG_TRIG_FALL] ?
		(~pick(src_vec, q.src_q[SRC_START +: SEL_W])
		& pick(q.src_prev_q, q.src_q[SRC_START +: SEL_W])) :
		(pick(src_vec, q.src_q[SRC_START +: SEL_W])
		& ~pick(q.src_prev_q, q.src_q[SRC_START +: SEL_W]));

	always_comb begin
		rd_val = '0;
		case (avs_address)
			OFF_CFG: rd_val[CFG_W-1:0] = q.cfg_q;
			OFF_SRC: rd_val[SRC_W-1:0] = q.src_q;
			OFF_REF: rd_val[N_CH-1:0] = q.ref_q;
			OFF_RGL: rd_val[N_CH-1:0] = q.rgl_q;
			OFF_CNT: rd_val = q.cnt_q;
			OFF_DIV: rd_val[15:0] = q.div_q;
			OFF_DLY: rd_val[15:0] = q.dly_q;
			OFF_STAT: begin
				rd_val[STAT_RUN] = (q.st_q == AOWS_DELAY) || (q.st_q == AOWS_RUN);
				rd_val[STAT_UF] = q.uf_q;
				rd_val[STAT_FULL] = (q.lvl_q == FULL_LVL);
				rd_val[STAT_EMPTY] = (q.lvl_q == '0);
				rd_val[STAT_ARMED] = (q.st_q == AOWS_ARMED);
				rd_val[STAT_LVL +: AW+1] = q.lvl_q;
			end
			default: rd_val = '0;
		endcase
	end

	always_comb begin
		n = q;
		go = 1'b0;
		stop = 1'b0;
		clr = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		fire = 1'b0;
		start = 1'b0;
		n.upd_q = 1'b0;
		n.strt_q = 1'b0;
		n.sclk_q = 1'b0;
		n.tb_prev_q = sample_clock_timebase;
		n.src_prev_q = src_vec;
		// answer every request one cycle after it appears
		n.wait_q = ~((avs_read | avs_write) & q.wait_q);
		if (avs_read & q.wait_q) begin
			n.rdata_q = rd_val;
		end
		if (commit) begin
			case (avs_address)
				OFF_CTRL: begin
					go = avs_writedata[CTRL_GO];
					stop = avs_writedata[CTRL_STOP];
					clr = avs_writedata[CTRL_CLR] && (q.st_q == AOWS_IDLE);
				end
				OFF_CFG: n.cfg_q = avs_writedata[CFG_W-1:0];
				OFF_SRC: n.src_q = avs_writedata[SRC_W-1:0];
				OFF_REF: n.ref_q = avs_writedata[N_CH-1:0];
				OFF_RGL: n.rgl_q = avs_writedata[N_CH-1:0];
				OFF_CNT: n.cnt_q = avs_writedata;
				OFF_DIV: n.div_q = avs_writedata[15:0];
				OFF_DLY: n.dly_q = avs_writedata[15:0];
				OFF_DATA: begin
					if (!hw) begin
						n.dac_q = avs_writedata[SMP_W-1:0];
						n.upd_q = 1'b1;
					end else if (!locked && (q.lvl_q != FULL_LVL)) begin
						push = 1'b1;
					end
				end
				OFF_STAT: begin
					if (avs_writedata[STAT_UF]) begin
						n.uf_q = 1'b0;
					end
				end
				default: n.wait_q = 1'b1;
			endcase
		end
		if (stop) begin
			n.st_q = AOWS_IDLE;
		end else begin
			case (q.st_q)
				AOWS_IDLE: begin
					if (go && hw) begin
						if (q.cfg_q[CFG_TRIG_EN]) begin
							n.st_q = AOWS_ARMED;
						end else begin
							start = 1'b1;
						end
					end
				end
				AOWS_ARMED: start = trig_edge;
				AOWS_DELAY: begin
					if (tb_edge) begin
						if (q.tb_cnt_q + 16'h0001 >= q.dly_q) begin
							n.st_q = AOWS_RUN;
							n.tb_cnt_q = '0;
							fire = ~paused;
						end else begin
							n.tb_cnt_q = q.tb_cnt_q + 16'h0001;
						end
					end
				end
				AOWS_RUN: begin
					if (ext) begin
						fire = clk_edge & ~paused;
					end else if (tb_edge && !paused) begin
						if (q.tb_cnt_q + 16'h0001 >= q.div_q) begin
							n.tb_cnt_q = '0;
							fire = 1'b1;
						end else begin
							n.tb_cnt_q = q.tb_cnt_q + 16'h0001;
						end
					end
				end
				default: n.st_q = AOWS_IDLE;
			endcase
		end
		if (start) begin
			n.strt_q = 1'b1;
			n.smp_q = '0;
			n.tb_cnt_q = '0;
			n.base_q = q.rd_q;
			n.st_q = ext ? AOWS_RUN : AOWS_DELAY;
		end
		// pause gates the launch of a sample and holds the divider count, so an update
		// already issued always completes
		if (fire) begin
			n.sclk_q = 1'b1;
			if (q.lvl_q == '0) begin
				if (regen == REGEN_NONE) begin
					n.uf_q = 1'b1;
				end
			end else begin
				n.dac_q = q.mem_q[q.rd_q];
				n.upd_q = 1'b1;
				n.smp_q = q.smp_q + 32'h00000001;
				if (regen == REGEN_FIFO) begin
					n.rd_q = (q.rd_q + 1'b1 == q.wr_q) ? q.base_q
						: q.rd_q + 1'b1;
				end else begin
					pop = 1'b1;
				end
				if (!cont && (q.smp_q + 32'h00000001 >= q.cnt_q)) begin
					n.st_q = AOWS_IDLE;
				end
			end
		end
		if (push) begin
			n.mem_q[q.wr_q] = avs_writedata[SMP_W-1:0];
			n.wr_q = q.wr_q + 1'b1;
		end
		if (pop) begin
			n.rd_q = q.rd_q + 1'b1;
		end
		n.lvl_q = q.lvl_q + (AW+1)'(push) - (AW+1)'(pop);
		if (clr) begin
			n.wr_q = '0;
			n.rd_q = '0;
			n.lvl_q = '0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.wait_q <= 1'b1;
			q.cfg_q <= CFG_RST;
			q.src_q <= SRC_RST;
			q.rgl_q <= '0;
			q.cnt_q <= CNT_RST;
			q.div_q <= DIV_RST;
			q.dly_q <= DLY_RST;
			q.st_q <= AOWS_IDLE;
		end else begin
			q <= n;
		end
	end

	assign avs_readdata = q.rdata_q;
	assign avs_waitrequest = q.wait_q;
	assign start_trigger_pin_o = q.strt_q;
	assign start_trigger_pin_oe = q.cfg_q[CFG_TRIG_OUT];
	assign output_sample_clock = q.sclk_q;
	assign dac_data = q.dac_q;
	assign dac_update = q.upd_q;
	assign ref_ext_sel = q.ref_q;
	assign reglitch_en = q.rgl_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence data_cmd_s;
		commit && (avs_address == OFF_DATA);
	endsequence
	sequence go_cmd_s;
		commit && (avs_address == OFF_CTRL) && avs_writedata[CTRL_GO];
	endsequence

	bus_answer_a: assert property ((avs_read || avs_write) && q.wait_q
		|=> !q.wait_q ##1 q.wait_q)
		else $error("request not answered in one cycle");
	sw_update_a: assert property (data_cmd_s and !hw
		|=> dac_update && dac_data == $past(avs_writedata[SMP_W-1:0]))
		else $error("software write gave no single update");
	hw_update_a: assert property (dac_update && hw
		|-> output_sample_clock)
		else $error("timed update without sample clock");
	sw_start_a: assert property (go_cmd_s and (q.st_q == AOWS_IDLE)
		and hw and !q.cfg_q[CFG_TRIG_EN] and !avs_writedata[CTRL_STOP]
		|=> start_trigger_pin_o ##1 !start_trigger_pin_o)
		else $error("software start missing one-cycle trigger");
	finite_stop_a: assert property (dac_update && hw && !cont
		&& q.smp_q >= q.cnt_q |-> q.st_q == AOWS_IDLE)
		else $error("finite run did not stop at count");
	underflow_a: assert property (fire && q.lvl_q == '0
		&& regen == REGEN_NONE |=> q.uf_q ##1 q.uf_q)
		else $error("empty fifo at sample without underflow");
	uf_sticky_a: assert property (q.uf_q && !(commit
		&& avs_address == OFF_STAT) |=> q.uf_q)
		else $error("underflow flag dropped on its own");
	pause_a: assert property (paused && hw
		&& q.st_q == AOWS_RUN && !commit |=> !dac_update)
		else $error("update while paused");
	stop_a: assert property (commit && avs_address == OFF_CTRL
		&& avs_writedata[CTRL_STOP] |=> q.st_q == AOWS_IDLE && !dac_update)
		else $error("stop did not halt generation");
	regen_lock_a: assert property (data_cmd_s and locked
		|=> $stable(q.wr_q))
		else $error("fifo written during fifo regeneration");
	delay_a: assert property (start && !ext && q.dly_q > 16'h0001
		|=> q.st_q == AOWS_DELAY && !output_sample_clock)
		else $error("first sample came before start delay");
endmodule : aows_sequencer

// ==== aows_host_model.sv ====
// host-side avalon master model that places register and sample traffic
`timescale 1ns/1ps
module aows_host_model import aows_pkg::*; (
	input wire logic core_clk,
	input wire logic avs_waitrequest,
	input wire logic [BUS_W-1:0] avs_readdata,
	output logic [ADDR_W-1:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [BUS_W-1:0] avs_writedata
);
	initial begin
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
	end

	// one command per access; each sample is a single word write
	task automatic xfer(input logic we, input logic [ADDR_W-1:0] a,
		input logic [BUS_W-1:0] d, output logic [BUS_W-1:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= ~we;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : xfer
endmodule : aows_host_model

// ==== analog_output_waveform_sequencer_tb_top.sv ====
// self-checking bench for the waveform sequencer
`timescale 1ns/1ps
module analog_output_waveform_sequencer_tb_top import aows_pkg::*;;
	logic core_clk, arst_n, tbase, st_i, st_o, st_oe, sclk, upd, rd, wr, wt;
	logic [ADDR_W-1:0] adr;
	logic [BUS_W-1:0] wd, rdat, v;
	logic [8:0] programmable_function_input;
	logic [31:0] dd;
	logic [1:0] rsel, rgl;
	int bad_count, n_tests, n_upd, n_trig, n_sclk, cyc, u0, s0, t0;

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	aows_sequencer u_aows_sequencer (.core_clk(core_clk), .arst_n(arst_n),
		.avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
		.sample_clock_timebase(tbase), .pfi_in(programmable_function_input), .sib_line(7'h00),
		.int_sig(4'h0), .start_trigger_pin_i(st_i),
		.start_trigger_pin_o(st_o), .start_trigger_pin_oe(st_oe),
		.output_sample_clock(sclk), .dac_data(dd), .dac_update(upd),
		.ref_ext_sel(rsel), .reglitch_en(rgl));

	aows_host_model u_aows_host_model (.core_clk(core_clk),
		.avs_waitrequest(wt), .avs_readdata(rdat), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd));

	task final_report;
		$display("compares %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task w(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
		logic [BUS_W-1:0] q;
		u_aows_host_model.xfer(1'b1, a, d, q);
	endtask : w

	task r(input logic [ADDR_W-1:0] a);
		u_aows_host_model.xfer(1'b0, a, 32'h00000000, v);
	endtask : r

	// timebase ticks every second clock so samples stay a few cycles apart
	always @(posedge core_clk) begin
		tbase <= ~tbase;
		cyc++;
		if (upd === 1'b1) n_upd++;
		if (st_o === 1'b1) n_trig++;
		if (sclk === 1'b1) n_sclk++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end

	initial begin
		arst_n = 1'b0;
		tbase = 1'b0;
		st_i = 1'b0;
		programmable_function_input = 9'h000;
		{bad_count, n_tests, n_upd, n_trig, n_sclk, cyc} = '0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		chk(32'(rgl), 32'h0);
		chk(32'(st_oe), 32'h0);
		r(OFF_DLY); chk(v, 32'h2);
		r(OFF_STAT); chk(v, 32'h8);
		w(OFF_REF, 32'h1);
		// the register takes the write at the accept edge; look one edge later
		@(posedge core_clk);
		chk(32'(rsel), 32'h1);
		w(6'h3C, 32'h3); r(OFF_REF); chk(v, 32'h1);
		w(OFF_RGL, 32'h2);
		@(posedge core_clk);
		chk(32'(rgl), 32'h2);
		$display("register test done");
		u0 = n_upd;
		w(OFF_DATA, 32'h1234ABCD);
		repeat (3) @(posedge core_clk);
		chk(32'(n_upd - u0), 32'h1);
		chk(dd, 32'h1234ABCD);
		$display("software timed test done");
		w(OFF_CFG, 32'h1);
		w(OFF_CNT, 32'h2);
		w(OFF_DATA, 32'h11112222);
		w(OFF_DATA, 32'h33334444);
		w(OFF_DATA, 32'h55556666);
		u0 = n_upd;
		t0 = n_trig;
		w(OFF_CTRL, 32'h1);
		repeat (80) @(posedge core_clk);
		chk(32'(n_upd - u0), 32'h2);
		chk(32'(n_trig - t0), 32'h1);
		chk(dd, 32'h33334444);
		r(OFF_STAT); chk(v & 32'h1F01, 32'h100);
		$display("finite test done");
		w(OFF_CFG, 32'h15);
		w(OFF_CTRL, 32'h1);
		repeat (40) @(posedge core_clk);
		r(OFF_STAT); chk(v & 32'h3, 32'h3);
		w(OFF_CTRL, 32'h2);
		r(OFF_STAT); chk(v & 32'h3, 32'h2);
		w(OFF_STAT, 32'h2);
		r(OFF_STAT); chk(v & 32'h2, 32'h0);
		$display("underflow test done");
		w(OFF_CFG, 32'h221);
		w(OFF_CTRL, 32'h1);
		u0 = n_trig;
		r(OFF_STAT); chk(v & 32'h11, 32'h10);
		chk(32'(st_oe), 32'h1);
		st_i <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk(32'(n_trig - u0), 32'h1);
		r(OFF_STAT); chk(v & 32'h1, 32'h1);
		chk(v & 32'h2, 32'h0);
		w(OFF_CTRL, 32'h2);
		st_i <= 1'b0;
		$display("start trigger test done");
		w(OFF_CTRL, 32'h4);
		w(OFF_SRC, 32'h100);
		w(OFF_CFG, 32'h185);
		programmable_function_input <= 9'h001;
		w(OFF_DATA, 32'h0F0F0F0F);
		w(OFF_DATA, 32'h0E0E0E0E);
		u0 = n_upd;
		w(OFF_CTRL, 32'h1);
		repeat (60) @(posedge core_clk);
		chk(32'(n_upd - u0), 32'h0);
		programmable_function_input <= 9'h000;
		repeat (40) @(posedge core_clk);
		chk(32'(n_upd - u0 != 0), 32'h1);
		chk(dd, 32'h0E0E0E0E);
		w(OFF_CTRL, 32'h2);
		$display("pause test done");
		// external clock on pfi 1, falling start on pfi 2, active-low pause on pfi 3
		w(OFF_CTRL, 32'h4);
		w(OFF_SRC, 32'h20403);
		w(OFF_CFG, 32'h0E3);
		programmable_function_input <= 9'h004;
		w(OFF_DATA, 32'hC1C1C1C1);
		w(OFF_DATA, 32'hC2C2C2C2);
		u0 = n_upd;
		s0 = n_sclk;
		w(OFF_CTRL, 32'h1);
		programmable_function_input <= 9'h000;
		repeat (2) @(posedge core_clk);
		programmable_function_input <= 9'h002;
		repeat (2) @(posedge core_clk);
		programmable_function_input <= 9'h000;
		repeat (2) @(posedge core_clk);
		chk(32'(n_upd - u0), 32'h0);
		chk(32'(n_sclk - s0), 32'h0);
		r(OFF_STAT);
		chk(v & 32'h1, 32'h1);
		programmable_function_input <= 9'h008;
		repeat (3) begin
			repeat (2) @(posedge core_clk);
			programmable_function_input <= 9'h00A;
			repeat (2) @(posedge core_clk);
			programmable_function_input <= 9'h008;
		end
		repeat (4) @(posedge core_clk);
		chk(32'(n_upd - u0), 32'h2);
		chk(32'(n_sclk - s0), 32'h2);
		chk(dd, 32'hC2C2C2C2);
		r(OFF_STAT);
		chk(v & 32'h1, 32'h0);
		$display("external clock test done");
		w(OFF_CTRL, 32'h4);
		w(OFF_CFG, 32'h00D);
		w(OFF_DATA, 32'hA1A1A1A1);
		w(OFF_DATA, 32'hB2B2B2B2);
		u0 = n_upd;
		w(OFF_CTRL, 32'h1);
		repeat (40) @(posedge core_clk);
		// replay is running, so this word must be refused
		w(OFF_DATA, 32'h77777777);
		r(OFF_STAT);
		chk((v >> 8) & 32'h1F, 32'h2);
		chk(v & 32'h1, 32'h1);
		chk(32'(n_upd - u0 > 2), 32'h1);
		w(OFF_CTRL, 32'h2);
		$display("fifo regeneration test done");
		final_report();
	end
endmodule : analog_output_waveform_sequencer_tb_top
